// >>> hdl/pcf_fanout.v
// Operation
// - Enabled bank toggles with reference frequency, phase
// - Disabled bank outputs held low
// - Ten outputs share one enable
// - Outputs have fifty percent duty cycle except in bypass or before a usable period is known, where the reference duty is passed on
// - Feedback output always toggles
// - Align feedback return edges to reference
// - Grounded analog supply bypasses loop
// - Stabilization interval before lock
// - Lock only after a 1 ms wait on a stable reference period
`timescale 1ns/1ps
`include "pcf_map.vh"
module pcf_fanout #(
    parameter LOCK_CYC = `PCF_LOCK_CYC
) (
    input wire clk,
    input wire nrst,
    input wire ref_clk_in,
    input wire feedback_return_input,
    input wire bank_enable,
    input wire analog_supply_pin,
    output wire [`PCF_BANK_W-1:0] bank_clock_outputs,
    output wire feedback_drive_output,
    output wire locked
);
    localparam ST_ACQ = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_BYP = 2'h2;
    localparam [`PCF_PER_W-1:0] PER_ONE = {{(`PCF_PER_W-1){1'b0}}, 1'b1};
    localparam [`PCF_PER_W-1:0] HALF_MIN = `PCF_HALF_MIN;

    wire [3:0] pin_s;
    wire ref_s;
    wire fb_s;
    wire en_s;
    wire analog_supply_pin_s;
    reg ref_d1_q;
    reg fb_d1_q;
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [31:0] lock_cnt_q;
    reg [`PCF_PER_W-1:0] per_cnt_q;
    reg [`PCF_PER_W-1:0] half_q;
    reg [`PCF_PER_W-1:0] gen_cnt_q;
    reg gen_q;
    reg en_q;
    reg [`PCF_BANK_W-1:0] bank_q;
    reg fbo_q;
    reg locked_q;
    reg [`PCF_PER_W-1:0] lead_q;
    wire ref_rise;
    wire fb_rise;
    wire gen_lvl;
    wire per_chg;
    reg sel_ref_q;

    pcf_sync2 #(.W(4)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({analog_supply_pin, bank_enable, feedback_return_input, ref_clk_in}),
        .dout(pin_s)
    );
    assign ref_s = pin_s[0];
    assign fb_s = pin_s[1];
    assign en_s = pin_s[2];
    assign analog_supply_pin_s = pin_s[3];

    assign ref_rise = ref_s & ~ref_d1_q;
    assign fb_rise = fb_s & ~fb_d1_q;

    function [`PCF_PER_W-1:0] half_of;
        input [`PCF_PER_W-1:0] p;
        begin
            half_of = {1'b0, p[`PCF_PER_W-1:1]};
        end
    endfunction

    // A new half-period length (period halved, rounded down) restarts the stabilization wait
    assign per_chg = ref_rise && (half_of(per_cnt_q) != half_q);

    // Next loop state
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_ACQ: begin
                if (analog_supply_pin_s == `PCF_BYPASS_LVL) begin
                    st_d = ST_BYP;
                end else if (!per_chg && lock_cnt_q >= LOCK_CYC) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (analog_supply_pin_s == `PCF_BYPASS_LVL) begin
                    st_d = ST_BYP;
                end else if (per_chg) begin
                    st_d = ST_ACQ;
                end
            end
            ST_BYP: begin
                // Leaving bypass needs a fresh stabilization wait
                if (analog_supply_pin_s != `PCF_BYPASS_LVL) st_d = ST_ACQ;
            end
            default: st_d = ST_ACQ;
        endcase
    end

    // Edge detectors and loop state
    always @(posedge clk) begin
        if (!nrst) begin
            ref_d1_q <= 1'b0;
            fb_d1_q <= 1'b0;
            st_q <= ST_ACQ;
        end else begin
            ref_d1_q <= ref_s;
            fb_d1_q <= fb_s;
            st_q <= st_d;
        end
    end

    // Reference period between rising edges; saturates if the reference stops
    always @(posedge clk) begin
        if (!nrst) begin
            per_cnt_q <= {`PCF_PER_W{1'b0}};
            half_q <= {`PCF_PER_W{1'b0}};
        end else if (ref_rise) begin
            per_cnt_q <= PER_ONE;
            if (per_chg) half_q <= half_of(per_cnt_q);
        end else if (per_cnt_q != {`PCF_PER_W{1'b1}}) begin
            per_cnt_q <= per_cnt_q + PER_ONE;
        end
    end

    // Stabilization wait, counted only while acquiring
    always @(posedge clk) begin
        if (!nrst) begin
            lock_cnt_q <= 32'h0000_0000;
        end else if (st_q != ST_ACQ || per_chg) begin
            lock_cnt_q <= 32'h0000_0000;
        end else if (lock_cnt_q != 32'hffff_ffff) begin
            lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
        end
    end

    // Generator regenerates a square wave of equal halves
    always @(posedge clk) begin
        if (!nrst) begin
            gen_cnt_q <= {`PCF_PER_W{1'b0}};
            gen_q <= 1'b0;
        end else if (ref_rise) begin
            gen_q <= 1'b1;
            // A lead that would leave a one-cycle high is dropped for this period
            if (gen_q || (lead_q + PER_ONE) < half_q) begin
                gen_cnt_q <= lead_q;
            end else begin
                gen_cnt_q <= {`PCF_PER_W{1'b0}};
            end
        end else if (gen_cnt_q + PER_ONE >= half_q) begin
            gen_q <= ~gen_q;
            gen_cnt_q <= {`PCF_PER_W{1'b0}};
        end else begin
            gen_cnt_q <= gen_cnt_q + PER_ONE;
        end
    end

    // Feedback lag is measured and pre-advanced on the next period
    always @(posedge clk) begin
        if (!nrst) begin
            lead_q <= {`PCF_PER_W{1'b0}};
        end else if (fb_rise && per_cnt_q < half_q) begin
            lead_q <= per_cnt_q;
        end
    end

    // Source select moves only while both sources are low, so a switch
    // into or out of bypass cannot leave a sliver pulse on the outputs.
    // Until a usable period is known the reference itself is passed on.
    always @(posedge clk) begin
        if (!nrst) begin
            sel_ref_q <= 1'b1;
        end else if (!gen_q && !ref_s) begin
            sel_ref_q <= (st_q == ST_BYP) || (half_q < HALF_MIN);
        end
    end

    // Bypass passes the synchronised reference unchanged
    assign gen_lvl = sel_ref_q ? ref_s : gen_q;

    // Enable is only sampled while the clock is low, so no runt pulse
    always @(posedge clk) begin
        if (!nrst) begin
            en_q <= 1'b0;
        end else if (!gen_lvl) begin
            en_q <= en_s;
        end
    end

    // All outputs launch from flops on the same edge to keep the bank aligned
    always @(posedge clk) begin
        if (!nrst) begin
            bank_q <= {`PCF_BANK_W{1'b0}};
            fbo_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            bank_q <= {`PCF_BANK_W{gen_lvl & en_q}};
            fbo_q <= gen_lvl;
            locked_q <= (st_q == ST_RUN);
        end
    end

    assign bank_clock_outputs = bank_q;
    assign feedback_drive_output = fbo_q;
    assign locked = locked_q;
endmodule // pcf_fanout

// >>> pkg/pcf_map.vh
`ifndef PCF_MAP_VH
`define PCF_MAP_VH

// Bank size
`define PCF_BANK_W 10
// Lock wait: 1 ms at 25 MHz (40 ns period)
`define PCF_LOCK_TIME_US 1000
`define PCF_CLK_PERIOD_NS 40
`define PCF_LOCK_CYC ((`PCF_LOCK_TIME_US * 1000) / `PCF_CLK_PERIOD_NS)
// Phase counter width for half-period measurement
`define PCF_PER_W 16
// Shortest half period the generator may run on; below it the reference passes through
`define PCF_HALF_MIN 16'h0002
// Bypass strap level: analog supply grounded
`define PCF_BYPASS_LVL 1'b0

`endif

// >>> hdl/pcf_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of pin levels
module pcf_sync2 #(
    parameter W = 1
) (
    input wire clk,
    input wire nrst,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;

    always @(posedge clk) begin
        if (!nrst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end

    assign dout = s2_q;
endmodule // pcf_sync2

// >>> dv/pcf_fanout_properties.sv
`timescale 1ns/1ps
module pcf_chk (
    input wire clk,
    input wire nrst,
    input wire bank_enable,
    input wire analog_supply_pin,
    input wire [9:0] bank_clock_outputs,
    input wire feedback_drive_output,
    input wire locked
);
    wire f = feedback_drive_output;
    wire [9:0] b = bank_clock_outputs;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_eq; b == 10'h0 || b == 10'h3ff; endproperty
    a_eq: assert property (p_eq) else $error("bank split");
    property p_on; bank_enable[*6] ##1 (bank_enable && $rose(f)) |-> b == 10'h3ff; endproperty
    a_on: assert property (p_on) else $error("bank idle");
    property p_off; !bank_enable[*6] ##1 (!bank_enable && $rose(f)) |-> b == 10'h0; endproperty
    a_off: assert property (p_off) else $error("bank runs");
    property p_cut; b[0] != $past(b[0]) |-> b[0] == f; endproperty
    a_cut: assert property (p_cut) else $error("cut pulse");
    property p_min; $rose(f) |=> f; endproperty
    a_min: assert property (p_min) else $error("short high");
    property p_run; $fell(f) |-> ##[1:40] $rose(f); endproperty
    a_run: assert property (p_run) else $error("feedback stuck");
    property p_byp; !analog_supply_pin[*5] |-> !locked; endproperty
    a_byp: assert property (p_byp) else $error("lock in bypass");
    property p_lock; $rose(locked) |-> $past(analog_supply_pin, 8); endproperty
    a_lock: assert property (p_lock) else $error("early lock");
endmodule // pcf_chk
bind pcf_fanout pcf_chk u_chk (.*);

// >>> dv/pcf_ref_model.sv
`timescale 1ns/1ps
module pcf_ref_model (
    input wire clk,
    output reg ref_clk
);
    reg [3:0] c = 4'h0;
    initial ref_clk = 1'b0;
    // Period of 12 cycles, 5 high: fixed rate, duty inside the allowed band
    // Rate is scaled to the sampling clock, a fixed in-range stand-in for the real source
    always @(negedge clk) begin
        c <= (c == 4'hb) ? 4'h0 : c + 4'h1;
        ref_clk <= c < 4'h5;
    end
endmodule // pcf_ref_model

// >>> dv/pcf_fanout_tb.sv
`timescale 1ns/1ps
module pcf_fanout_tb;
    reg clk = 1'b0, nrst = 1'b0, en = 1'b1, av = 1'b1;
    wire rc, fb, lk;
    wire [9:0] b;
    integer err_count = 0, n_tests = 0, h, l, i;
    always #20 clk = ~clk;
    pcf_ref_model rm (.clk(clk), .ref_clk(rc));
    // Feedback output wired straight back, as on the board
    pcf_fanout #(.LOCK_CYC(50)) uut (.clk(clk), .nrst(nrst), .ref_clk_in(rc),
        .feedback_return_input(fb), .bank_enable(en), .analog_supply_pin(av),
        .bank_clock_outputs(b), .feedback_drive_output(fb), .locked(lk));
    task cy; begin @(posedge clk); #1; end endtask
    task chk(input [15:0] s, input [15:0] e, input string n); begin
        n_tests = n_tests + 1;
        if (s !== e) begin
            err_count = err_count + 1;
            $display("Error %0s exp %0h got %0h", n, e, s);
        end
    end endtask
    task wt(input v); for (i = 0; i < 400 && fb !== v; i = i + 1) cy; endtask
    task meas; begin
        wt(1'b0);
        wt(1'b1);
        for (h = 0; h < 99 && fb === 1'b1; h = h + 1) cy;
        for (l = 0; l < 99 && fb === 1'b0; l = l + 1) cy;
    end endtask
    task test_done; begin
        $display("%0d checks, %0d errors", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end endtask
    task t_lock; begin
        repeat (20) cy;
        chk(lk, 0, "lock");
        for (i = 0; i < 400 && lk !== 1'b1; i = i + 1) cy;
        chk(lk, 1, "lock");
        meas;
        chk(h, 6, "high");
        chk(l, 6, "low");
        wt(1'b1);
        chk(b, 10'h3ff, "bank");
    end endtask
    task t_off; begin
        @(posedge clk) en <= 1'b0;
        meas;
        meas;
        chk(b, 0, "bank");
        chk(h, 6, "high");
        @(posedge clk) en <= 1'b1;
    end endtask
    task t_byp; begin
        @(posedge clk) av <= 1'b0;
        repeat (20) cy;
        meas;
        chk(h, 5, "bypass");
        chk(lk, 0, "lock");
        @(posedge clk) av <= 1'b1;
        cy;
        chk(lk, 0, "lock");
    end endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_lock;
        t_off;
        t_byp;
        test_done;
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        err_count = err_count + 1;
        test_done;
    end
endmodule // pcf_fanout_tb
